// ---- design/bfp_pin_sync.sv ----
`timescale 1ns/1ps

module bfp_pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Asynchronous pins and filtered levels
   input  wire logic [W-1:0] pin_async,
   output logic      [W-1:0] pin_level
);

   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;
   logic [W-1:0] stage3_reg;
   wire  [W-1:0] agree = ~(stage2_reg ^ stage3_reg);
   wire  [W-1:0] level_next = (agree & stage2_reg) | (~agree & pin_level);

   // A change is taken only once the second and third stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         pin_level  <= '0;
      end else begin
         stage1_reg <= pin_async;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         pin_level  <= level_next;
      end
   end

endmodule

// ---- design/bfp_sequencer.sv ----
//
// Behaviour
// - Valley current is compared with the selected limit only while low side conducts.
// - Above the limit, low side stays on and the next high-side pulse waits.
// - Feedback below 70% for 1 ms while present shuts switching down.
// - After undervoltage shutdown, stay off 7 ms, then restart automatically.
// - Current limit during soft start goes to hiccup at once, no wait.
// - Bias rail below lockout stops everything; resumes unlatched when it recovers.
// - Die overtemperature shuts off; recovery is automatic and unlatched.
// - Overtemperature at start-up blocks switching and mode capture until it clears.
// - Overtemperature after start-up stops switching, resets soft start, discharges output.
// - Recovery from overtemperature restarts with the held mode, no new sampling.
// - Discharge switch on for overvoltage, undervoltage, thermal, lockout, enable low.
// - Forced-continuous mode switches every cycle and never skips pulses.
// - Pulse-skip mode turns low side off at zero valley current, skipping pulses.
// - Mode sampled once at start-up from twelve codes; held until power cycle.
// - Mode read takes 144 us after lockout clears, before soft start.
// - Power good released after 14 us in 93..108% window; low otherwise.
//
`timescale 1ns/1ps
`include "bfp_regs.svh"

module bfp_sequencer #(
   parameter int TICK_CYCLES     = `BFP_TICK_NS / `BFP_CLK_PERIOD_NS,
   parameter int UV_WAIT_TICKS   = `BFP_UV_WAIT_US * 1000 / `BFP_TICK_NS,
   parameter int HICCUP_TICKS    = `BFP_HICCUP_US * 1000 / `BFP_TICK_NS,
   parameter int MODE_READ_TICKS = `BFP_MODE_READ_US * 1000 / `BFP_TICK_NS,
   parameter int PG_TICKS        = `BFP_PG_DEGLITCH_US * 1000 / `BFP_TICK_NS,
   parameter int TIMER_W         = 13,
   parameter int TICK_W          = 8,
   parameter int PG_W            = 5
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Comparator and pin inputs
   input  wire logic        current_limit_lower_trip,
   input  wire logic        current_limit_upper_trip,
   input  wire logic        feedback_sense_below_uv,
   input  wire logic        feedback_sense_above_ov,
   input  wire logic        feedback_sense_in_window,
   input  wire logic        internal_bias_rail_ok,
   input  wire logic        die_overtemp_flag,
   input  wire logic        enable_pin,
   input  wire logic        inductor_zero_cross,
   input  wire logic        pwm_demand,
   input  wire logic        soft_start_done,
   input  wire logic [3:0]  mode_code,
   // Power stage controls
   output logic             high_side_on,
   output logic             low_side_on,
   output logic             soft_start_reset,
   output logic             discharge_on,
   output logic [1:0]       freq_select,
   // Open-drain power good
   output logic             output_in_regulation_flag_out,
   output logic             output_in_regulation_flag_oe_n,
   // Interrupt
   output logic             irq
);

   localparam int NSYNC = 15;

   // Returns {forced_continuous_conduction, upper limit, freq[1:0]}; unused codes fall back to code 0
   function automatic logic [3:0] decode_mode(input logic [3:0] code);
      logic [3:0] idx;
      idx = 4'h0;
      if (code < 4'(`BFP_MODE_FORCED_CONTINUOUS_CONDUCTION_CODES)) begin
         idx = code;
      end else if (code < 4'(`BFP_MODE_CODES)) begin
         idx = code - 4'(`BFP_MODE_FORCED_CONTINUOUS_CONDUCTION_CODES);
      end
      decode_mode = {code < 4'(`BFP_MODE_FORCED_CONTINUOUS_CONDUCTION_CODES) || code >= 4'(`BFP_MODE_CODES),
                     idx[0], idx[2:1]};
   endfunction

   // Synchronised pins
   logic [NSYNC-1:0] pins;
   bfp_pin_sync #(.W(NSYNC)) i_bfp_pin_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async ({mode_code, soft_start_done, pwm_demand, inductor_zero_cross,
                   enable_pin, die_overtemp_flag, internal_bias_rail_ok,
                   feedback_sense_in_window, feedback_sense_above_ov,
                   feedback_sense_below_uv, current_limit_upper_trip,
                   current_limit_lower_trip}),
      .pin_level (pins)
   );

   wire       lim_lower  = pins[0];
   wire       lim_upper  = pins[1];
   wire       fb_uv      = pins[2];
   wire       fb_ov      = pins[3];
   wire       fb_window  = pins[4];
   wire       bias_ok    = pins[5];
   wire       overtemp   = pins[6];
   wire       enable_s   = pins[7];
   wire       zero_cross = pins[8];
   wire       demand     = pins[9];
   wire       ss_done    = pins[10];
   wire [3:0] code_s     = pins[14:11];

   // State
   bfp_pkg::bfp_state_type state_reg;
   bfp_pkg::bfp_state_type state_next;
   logic [TIMER_W-1:0]     timer_reg;
   logic [TICK_W-1:0]      tick_cnt_reg;
   logic                   tick_reg;
   logic                   mode_valid_reg;
   logic [3:0]             mode_fields_reg;
   logic [3:0]             code_latched_reg;
   logic [PG_W-1:0]        pg_cnt_reg;
   logic                   standby_reg;
   logic [`BFP_INT_WIDTH-1:0] int_status_reg;
   logic [`BFP_INT_WIDTH-1:0] int_enable_reg;
   logic                   valley_trip_prev_reg;
   logic                   bias_ok_prev_reg;

   // Oscillator tick divider
   wire tick_wrap = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + TICK_W'(1);
         tick_reg     <= tick_wrap;
      end
   end

   // Interval timer on oscillator ticks; cleared on each state change
   wire uv_expired   = tick_reg && timer_reg == TIMER_W'(UV_WAIT_TICKS - 1);
   wire hic_expired  = tick_reg && timer_reg == TIMER_W'(HICCUP_TICKS - 1);
   wire read_expired = tick_reg && timer_reg == TIMER_W'(MODE_READ_TICKS - 1);

   wire forced_continuous_conduction_mode   = mode_fields_reg[3];
   wire upper_sel   = mode_fields_reg[2];
   wire limit_trip  = upper_sel ? lim_upper : lim_lower;
   wire valley_trip = low_side_on & limit_trip;
   wire stop_all    = !bias_ok || !enable_s || standby_reg;

   always_comb begin
      state_next = state_reg;
      if (stop_all) begin
         state_next = bfp_pkg::ST_OFF;
      end else if (overtemp && state_reg != bfp_pkg::ST_OFF &&
                   state_reg != bfp_pkg::ST_MODE_READ) begin
         state_next = bfp_pkg::ST_THERMAL;
      end else begin
         case (state_reg)
            bfp_pkg::ST_OFF:
               state_next = mode_valid_reg ? bfp_pkg::ST_SOFT_START : bfp_pkg::ST_MODE_READ;
            bfp_pkg::ST_MODE_READ:
               if (read_expired && !overtemp) begin
                  state_next = bfp_pkg::ST_SOFT_START;
               end
            bfp_pkg::ST_SOFT_START:
               if (valley_trip) begin
                  state_next = bfp_pkg::ST_HICCUP;
               end else if (ss_done) begin
                  state_next = bfp_pkg::ST_RUN;
               end
            bfp_pkg::ST_RUN:
               if (fb_uv) begin
                  state_next = bfp_pkg::ST_UV_WAIT;
               end
            bfp_pkg::ST_UV_WAIT:
               if (!fb_uv) begin
                  state_next = bfp_pkg::ST_RUN;
               end else if (uv_expired) begin
                  state_next = bfp_pkg::ST_HICCUP;
               end
            bfp_pkg::ST_HICCUP:
               if (hic_expired) begin
                  state_next = bfp_pkg::ST_SOFT_START;
               end
            bfp_pkg::ST_THERMAL:
               if (!overtemp) begin
                  state_next = mode_valid_reg ? bfp_pkg::ST_SOFT_START
                                              : bfp_pkg::ST_MODE_READ;
               end
            default:
               state_next = bfp_pkg::ST_OFF;
         endcase
      end
   end

   // Overtemperature during mode read holds the read timer at zero
   wire timer_clear = state_next != state_reg ||
                      (state_reg == bfp_pkg::ST_MODE_READ && overtemp);
   wire capture     = state_reg == bfp_pkg::ST_MODE_READ &&
                      state_next == bfp_pkg::ST_SOFT_START && !mode_valid_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= bfp_pkg::ST_OFF;
         timer_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (timer_clear) begin
            timer_reg <= '0;
         end else if (tick_reg) begin
            timer_reg <= timer_reg + TIMER_W'(1);
         end
      end
   end

   // Mode capture survives standby, lockout and thermal; only presetn clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_valid_reg   <= 1'b0;
         mode_fields_reg  <= 4'h0;
         code_latched_reg <= 4'h0;
      end else if (capture) begin
         mode_valid_reg   <= 1'b1;
         mode_fields_reg  <= decode_mode(code_s);
         code_latched_reg <= code_s;
      end
   end

   // Gate control
   wire switching = state_reg == bfp_pkg::ST_SOFT_START || state_reg == bfp_pkg::ST_RUN ||
                    state_reg == bfp_pkg::ST_UV_WAIT;
   wire hs_next   = switching && demand && !valley_trip;
   // Pulse-skip lets the low side open at zero current; forced-continuous never does
   wire ls_next   = switching && !hs_next &&
                    (valley_trip || forced_continuous_conduction_mode || !zero_cross);
   wire dis_next  = fb_ov || !bias_ok || !enable_s || standby_reg ||
                    state_reg == bfp_pkg::ST_HICCUP ||
                    state_reg == bfp_pkg::ST_THERMAL;

   // Power good deglitch
   wire pg_ok      = state_reg == bfp_pkg::ST_RUN && fb_window && !fb_uv && !fb_ov;
   wire pg_release = pg_cnt_reg == PG_W'(PG_TICKS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_side_on     <= 1'b0;
         low_side_on      <= 1'b0;
         soft_start_reset <= 1'b1;
         discharge_on     <= 1'b1;
         freq_select      <= 2'h0;
         pg_cnt_reg       <= '0;
         output_in_regulation_flag_out  <= 1'b0;
         output_in_regulation_flag_oe_n <= 1'b0;
      end else begin
         high_side_on     <= hs_next;
         low_side_on      <= ls_next;
         soft_start_reset <= !switching;
         discharge_on     <= dis_next;
         freq_select      <= mode_fields_reg[1:0];
         if (!pg_ok) begin
            pg_cnt_reg <= '0;
         end else if (tick_reg && !pg_release) begin
            pg_cnt_reg <= pg_cnt_reg + PG_W'(1);
         end
         output_in_regulation_flag_out  <= 1'b0;
         output_in_regulation_flag_oe_n <= pg_ok && pg_release;
      end
   end

   // Events
   logic [`BFP_INT_WIDTH-1:0] events;
   always_comb begin
      events = '0;
      events[`BFP_INT_UV_BIT]      = state_next == bfp_pkg::ST_HICCUP &&
                                     state_reg != bfp_pkg::ST_HICCUP;
      events[`BFP_INT_OCL_BIT]     = valley_trip && !valley_trip_prev_reg;
      events[`BFP_INT_OT_BIT]      = state_next == bfp_pkg::ST_THERMAL &&
                                     state_reg != bfp_pkg::ST_THERMAL;
      events[`BFP_INT_LOCKOUT_BIT] = bias_ok_prev_reg && !bias_ok;
      events[`BFP_INT_OUTPUT_IN_REGULATION_FLAG_BIT]   = pg_ok && pg_release && !output_in_regulation_flag_oe_n;
   end

   // APB decode; pready rises in the access phase, giving one access cycle
   wire access    = psel && penable && pready;
   wire sel_ctrl  = paddr == `BFP_ADDR_CONTROL;
   wire sel_stat  = paddr == `BFP_ADDR_STATUS;
   wire sel_ists  = paddr == `BFP_ADDR_INT_STATUS;
   wire sel_ien   = paddr == `BFP_ADDR_INT_ENABLE;
   wire sel_iclr  = paddr == `BFP_ADDR_INT_CLEAR;
   wire mapped    = sel_ctrl || sel_stat || sel_ists || sel_ien || sel_iclr;
   wire wr_ctrl   = access && pwrite && sel_ctrl;
   wire wr_ien    = access && pwrite && sel_ien;
   wire [`BFP_INT_WIDTH-1:0] clr_mask =
      (access && pwrite && sel_iclr) ? pwdata[`BFP_INT_WIDTH-1:0] : '0;

   wire [31:0] status_word =
      (32'(state_reg) << `BFP_STAT_STATE_LSB) |
      (32'(mode_valid_reg) << `BFP_STAT_VALID_BIT) |
      (32'(forced_continuous_conduction_mode) << `BFP_STAT_FORCED_CONTINUOUS_CONDUCTION_BIT) |
      (32'(upper_sel) << `BFP_STAT_UPPER_BIT) |
      (32'(mode_fields_reg[1:0]) << `BFP_STAT_FREQ_LSB) |
      (32'(output_in_regulation_flag_oe_n) << `BFP_STAT_OUTPUT_IN_REGULATION_FLAG_BIT) |
      (32'(code_latched_reg) << `BFP_STAT_CODE_LSB);
   wire [31:0] read_word =
      sel_ctrl ? (32'(standby_reg) << `BFP_CTRL_STANDBY_BIT) :
      sel_stat ? status_word :
      sel_ists ? 32'(int_status_reg) :
      sel_ien  ? 32'(int_enable_reg) : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? read_word : 32'h0000_0000;
      end
   end

   // Set wins over a clear that lands in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_reg          <= 1'(`BFP_CTRL_RESET);
         int_status_reg       <= `BFP_INT_RESET;
         int_enable_reg       <= `BFP_INT_RESET;
         valley_trip_prev_reg <= 1'b0;
         bias_ok_prev_reg     <= 1'b0;
         irq                  <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            standby_reg <= pwdata[`BFP_CTRL_STANDBY_BIT];
         end
         if (wr_ien) begin
            int_enable_reg <= pwdata[`BFP_INT_WIDTH-1:0];
         end
         int_status_reg       <= (int_status_reg & ~clr_mask) | events;
         valley_trip_prev_reg <= valley_trip;
         bias_ok_prev_reg     <= bias_ok;
         irq                  <= |(int_status_reg & int_enable_reg);
      end
   end

endmodule

// ---- pkg/bfp_pkg.sv ----
package bfp_pkg;

   typedef enum logic [6:0] {
      ST_OFF        = 7'h01,
      ST_MODE_READ  = 7'h02,
      ST_SOFT_START = 7'h04,
      ST_RUN        = 7'h08,
      ST_UV_WAIT    = 7'h10,
      ST_HICCUP     = 7'h20,
      ST_THERMAL    = 7'h40
   } bfp_state_type;

   typedef enum logic [1:0] {
      FREQ_400K  = 2'h0,
      FREQ_800K  = 2'h1,
      FREQ_1200K = 2'h2
   } bfp_freq_type;

endpackage

// ---- pkg/bfp_regs.svh ----
`ifndef BFP_REGS_SVH
`define BFP_REGS_SVH

// APB register byte offsets
`define BFP_ADDR_CONTROL    12'h000
`define BFP_ADDR_STATUS     12'h004
`define BFP_ADDR_INT_STATUS 12'h008
`define BFP_ADDR_INT_ENABLE 12'h00C
`define BFP_ADDR_INT_CLEAR  12'h010

// CONTROL fields
`define BFP_CTRL_STANDBY_BIT 0
`define BFP_CTRL_RESET       32'h0000_0000

// STATUS fields
`define BFP_STAT_STATE_LSB   0
`define BFP_STAT_VALID_BIT   8
`define BFP_STAT_FORCED_CONTINUOUS_CONDUCTION_BIT    9
`define BFP_STAT_UPPER_BIT   10
`define BFP_STAT_FREQ_LSB    11
`define BFP_STAT_OUTPUT_IN_REGULATION_FLAG_BIT   13
`define BFP_STAT_CODE_LSB    16

// Interrupt bit positions, shared by status, enable and clear
`define BFP_INT_WIDTH        5
`define BFP_INT_UV_BIT       0
`define BFP_INT_OCL_BIT      1
`define BFP_INT_OT_BIT       2
`define BFP_INT_LOCKOUT_BIT  3
`define BFP_INT_OUTPUT_IN_REGULATION_FLAG_BIT    4
`define BFP_INT_RESET        5'h00

// Timing
`define BFP_CLK_PERIOD_NS    8
`define BFP_TICK_NS          1000
`define BFP_UV_WAIT_US       1000
`define BFP_HICCUP_US        7000
`define BFP_MODE_READ_US     144
`define BFP_PG_DEGLITCH_US   14

// Mode configuration
`define BFP_MODE_CODES       12
`define BFP_MODE_FORCED_CONTINUOUS_CONDUCTION_CODES  6

`endif

// ---- tb/bfp_sequencer_asserts.sv ----
`timescale 1ns/1ps

module bfp_sequencer_asserts (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Comparator pins
   input wire logic current_limit_lower_trip,
   input wire logic current_limit_upper_trip,
   input wire logic feedback_sense_in_window,
   input wire logic internal_bias_rail_ok,
   input wire logic die_overtemp_flag,
   input wire logic enable_pin,
   // Stage controls
   input wire logic high_side_on,
   input wire logic low_side_on,
   input wire logic soft_start_reset,
   input wire logic discharge_on,
   input wire logic output_in_regulation_flag_oe_n
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Pins take 4 edges of sync and up to two registers, so 7 cycles of a level has settled
   a_gates_apart: assert property (!(high_side_on && low_side_on))
      else $error("both gates on");
   a_lockout_stops: assert property (!internal_bias_rail_ok [*7] |->
      discharge_on && !high_side_on && !low_side_on) else $error("switching in lockout");
   a_hot_stops: assert property (die_overtemp_flag [*7] |->
      !high_side_on && !low_side_on) else $error("switching while hot");
   a_hot_ramp_reset: assert property (die_overtemp_flag [*7] |-> soft_start_reset)
      else $error("ramp not held while hot");
   a_enable_discharge: assert property (!enable_pin [*7] |->
      discharge_on && !high_side_on) else $error("no discharge with enable low");
   a_pg_fault_low: assert property (!feedback_sense_in_window [*7] |->
      !output_in_regulation_flag_oe_n) else $error("power good out of window");
   a_pg_deglitch: assert property ($rose(output_in_regulation_flag_oe_n) |->
      $past(feedback_sense_in_window, 5) && $past(feedback_sense_in_window, 8))
      else $error("power good released early");
   a_valley_hold: assert property ((low_side_on && current_limit_lower_trip
      && current_limit_upper_trip) [*6] |=> !high_side_on) else $error("pulse over limit");
   a_reset_safe: assert property ($rose(presetn) |->
      discharge_on && !high_side_on && !low_side_on) else $error("unsafe after reset");
   a_bus_answer: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("bad ready timing");

   c_lockout_back: cover property (!internal_bias_rail_ok ##1 internal_bias_rail_ok);
   c_pg_release: cover property ($rose(output_in_regulation_flag_oe_n));
   c_hot_clear: cover property ($fell(die_overtemp_flag));
endmodule

bind bfp_sequencer bfp_sequencer_asserts i_bfp_sequencer_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .current_limit_lower_trip(current_limit_lower_trip),
   .current_limit_upper_trip(current_limit_upper_trip),
   .feedback_sense_in_window(feedback_sense_in_window),
   .internal_bias_rail_ok(internal_bias_rail_ok), .die_overtemp_flag(die_overtemp_flag),
   .enable_pin(enable_pin), .high_side_on(high_side_on), .low_side_on(low_side_on),
   .soft_start_reset(soft_start_reset), .discharge_on(discharge_on),
   .output_in_regulation_flag_oe_n(output_in_regulation_flag_oe_n)
);

// ---- tb/bfp_sequencer_bench.sv ----
`timescale 1ns/1ps
`include "bfp_regs.svh"

module bfp_sequencer_bench;
   logic        pclk, presetn, psel, penable, pwrite, err, lim, uv, ov, win, ok, hot, en;
   logic        light, dmd, zc, ssd, hs, ls, ssr, dis, pg_out, pg_oe_n, irq, any_ls, pready, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  freq;
   logic [3:0]  code;
   logic [7:0]  ramp;
   int          failures, checks, n;

   bfp_sequencer #(.TICK_CYCLES(2), .UV_WAIT_TICKS(10), .HICCUP_TICKS(20),
      .MODE_READ_TICKS(5), .PG_TICKS(3)) i_bfp_sequencer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(perr),
      .current_limit_lower_trip(lim), .current_limit_upper_trip(lim),
      .feedback_sense_below_uv(uv), .feedback_sense_above_ov(ov),
      .feedback_sense_in_window(win), .internal_bias_rail_ok(ok), .die_overtemp_flag(hot),
      .enable_pin(en), .inductor_zero_cross(zc), .pwm_demand(dmd), .soft_start_done(ssd),
      .mode_code(code), .high_side_on(hs), .low_side_on(ls), .soft_start_reset(ssr),
      .discharge_on(dis), .freq_select(freq), .output_in_regulation_flag_out(pg_out),
      .output_in_regulation_flag_oe_n(pg_oe_n), .irq(irq));

   bfp_stage_model i_bfp_stage_model (.pclk(pclk), .soft_start_reset(ssr),
      .light_load(light), .ramp_cycles(ramp), .soft_start_done(ssd), .pwm_demand(dmd),
      .inductor_zero_cross(zc));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, want);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_st(input logic [6:0] s);
      n = 0;
      do begin
         apb(1'b0, `BFP_ADDR_STATUS, 32'h0);
         n++;
      end while (rd[6:0] !== s && n < 200);
      chk(rd[6:0], s);
   endtask

   // Mode fields expected from the code's row order: six forced-continuous rows first
   function automatic logic [31:0] mode_exp(input int c);
      return (32'h1 << `BFP_STAT_VALID_BIT) | (32'(c < 6) << `BFP_STAT_FORCED_CONTINUOUS_CONDUCTION_BIT)
         | (32'(c % 2) << `BFP_STAT_UPPER_BIT) | (32'((c % 6) / 2) << `BFP_STAT_FREQ_LSB)
         | (32'(c) << `BFP_STAT_CODE_LSB);
   endfunction

   task automatic power_up(input logic [3:0] c, input logic t);
      presetn <= 1'b0;
      code <= c;
      hot <= t;
      en <= 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      stop_test();
   end

   initial begin
      failures = 0;
      checks = 0;
      {presetn, psel, penable, pwrite, lim, uv, ov, win, hot, en, light} = 11'h000;
      {paddr, pwdata, code} = '0;
      ok = 1'b1;
      ramp = 8'h04;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      chk({hs, ls, dis, ssr, pg_oe_n}, 5'b00110);
      wait_st(bfp_pkg::ST_OFF);
      apb(1'b0, 12'h020, 32'h0);
      chk({err, rd[7:0]}, 9'h100);
      apb(1'b1, `BFP_ADDR_INT_ENABLE, 32'h1F);
      apb(1'b0, `BFP_ADDR_INT_ENABLE, 32'h0);
      chk(rd, 32'h1F);
      for (int c = 0; c < 12; c++) begin
         power_up(c[3:0], 1'b0);
         repeat (12) @(posedge pclk);
         chk(ssr, 1'b1);
         wait_st(bfp_pkg::ST_RUN);
         chk(rd & 32'h000F_1F00, mode_exp(c));
         chk(freq, (c % 6) / 2);
         light <= 1'b1;
         repeat (8) @(posedge pclk);
         any_ls = 1'b0;
         repeat (16) begin
            @(posedge pclk);
            any_ls = any_ls | ls;
         end
         chk(any_ls, c < 6);
         light <= 1'b0;
      end
      power_up(4'h2, 1'b1);
      repeat (40) @(posedge pclk);
      apb(1'b0, `BFP_ADDR_STATUS, 32'h0);
      chk({rd[8], hs, ls}, 3'b000);
      hot <= 1'b0;
      wait_st(bfp_pkg::ST_RUN);
      code <= 4'h9;
      hot <= 1'b1;
      wait_st(bfp_pkg::ST_THERMAL);
      chk({dis, ssr, hs, ls}, 4'b1100);
      hot <= 1'b0;
      wait_st(bfp_pkg::ST_RUN);
      chk(rd & 32'h000F_1F00, mode_exp(2));
      chk(irq, 1'b0);
      apb(1'b1, `BFP_ADDR_INT_ENABLE, 32'h4);
      repeat (3) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, `BFP_ADDR_INT_CLEAR, 32'h4);
      repeat (3) @(posedge pclk);
      chk(irq, 1'b0);
      uv <= 1'b1;
      repeat (16) @(posedge pclk);
      chk(dis, 1'b0);
      wait_st(bfp_pkg::ST_HICCUP);
      chk({dis, ssr}, 2'b11);
      uv <= 1'b0;
      n = 0;
      while (dis === 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk(n >= 30 && n <= 44, 1'b1);
      wait_st(bfp_pkg::ST_RUN);
      apb(1'b1, `BFP_ADDR_INT_ENABLE, 32'h2);
      ramp <= 8'hC8;
      ok <= 1'b0;
      wait_st(bfp_pkg::ST_OFF);
      ok <= 1'b1;
      wait_st(bfp_pkg::ST_SOFT_START);
      lim <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(1'b0, `BFP_ADDR_STATUS, 32'h0);
      chk({rd[6:0], irq}, {bfp_pkg::ST_HICCUP, 1'b1});
      lim <= 1'b0;
      ramp <= 8'h04;
      wait_st(bfp_pkg::ST_RUN);
      lim <= 1'b1;
      repeat (12) @(posedge pclk);
      chk({hs, ls}, 2'b01);
      lim <= 1'b0;
      win <= 1'b1;
      n = 0;
      while (pg_oe_n !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      chk({pg_oe_n, pg_out, n >= 8}, 3'b101);
      win <= 1'b0;
      ov <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({pg_oe_n, dis}, 2'b01);
      ov <= 1'b0;
      en <= 1'b0;
      repeat (8) @(posedge pclk);
      chk({hs, ls, dis}, 3'b001);
      en <= 1'b1;
      wait_st(bfp_pkg::ST_RUN);
      apb(1'b1, `BFP_ADDR_CONTROL, 32'h1);
      wait_st(bfp_pkg::ST_OFF);
      apb(1'b1, `BFP_ADDR_CONTROL, 32'h0);
      wait_st(bfp_pkg::ST_RUN);
      stop_test();
   end
endmodule

// ---- tb/bfp_stage_model.sv ----
`timescale 1ns/1ps

module bfp_stage_model (
   // Clock and sequencer side
   input wire logic       pclk,
   input wire logic       soft_start_reset,
   // Bench controls
   input wire logic       light_load,
   input wire logic [7:0] ramp_cycles,
   // Analog replies
   output logic           soft_start_done,
   output logic           pwm_demand,
   output logic           inductor_zero_cross
);
   logic [7:0] ramp_cnt;
   logic [2:0] phase;

   initial begin
      ramp_cnt = 8'h00;
      phase = 3'h0;
   end

   // Ramp collapses to zero whenever held, so a slow ramp keeps soft start open
   always @(posedge pclk) begin
      phase <= phase + 3'h1;
      if (soft_start_reset) begin
         ramp_cnt <= 8'h00;
      end else if (ramp_cnt != 8'hFF) begin
         ramp_cnt <= ramp_cnt + 8'h01;
      end
   end

   assign soft_start_done = !soft_start_reset && (ramp_cnt >= ramp_cycles);
   assign pwm_demand = (phase < 3'h2);
   // Light load: valley sits at zero for the whole off time
   assign inductor_zero_cross = light_load;
endmodule
